// ---- fcst_pkg.sv ----
// Package: constants for the flash command and status host controller
// Assumes a 20 MHz system clock; all flash pins are sampled synchronously
package fcst_pkg;
  localparam int          CLK_MHZ          = 20;
  localparam int          ADDR_W           = 20;
  localparam int          DATA_W           = 16;
  // Times in their own units
  localparam int          T_RP_NS          = 500;
  localparam int          T_RH_NS          = 50;
  localparam int          T_READY_US       = 20;
  localparam int          T_OEHP_NS        = 90;
  localparam int          T_CMD_NS         = 100;
  localparam int          T_BUSY_NS        = 90;
  localparam int          T_BUSY_SUSP_NS   = 300;
  localparam int          T_SUSP_PROG_NS   = 1500;
  localparam int          T_SUSP_ERASE_US  = 15;
  localparam int          T_RESUME_US      = 1;
  // Cycle counts: least times round up, longest times round down
  localparam int          CYC_RP           = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int          CYC_RH           = (T_RH_NS * CLK_MHZ + 999) / 1000;
  localparam int          CYC_READY        = T_READY_US * CLK_MHZ;
  localparam int          CYC_OEHP         = (T_OEHP_NS * CLK_MHZ + 999) / 1000;
  localparam int          CYC_CMD          = (T_CMD_NS * CLK_MHZ + 999) / 1000;
  localparam int          CYC_BUSY         = (T_BUSY_NS * CLK_MHZ) / 1000 < 1 ? 1 : (T_BUSY_NS * CLK_MHZ) / 1000;
  localparam int          CYC_BUSY_SUSP    = (T_BUSY_SUSP_NS * CLK_MHZ) / 1000;
  localparam int          CYC_SUSP_PROG    = (T_SUSP_PROG_NS * CLK_MHZ) / 1000;
  localparam int          CYC_SUSP_ERASE   = T_SUSP_ERASE_US * CLK_MHZ;
  localparam int          CYC_RESUME       = T_RESUME_US * CLK_MHZ;
  localparam int          CNT_W            = 10;
  // Low address lines for protect verify: bit6, bit1, bit0 = 0, 1, 0
  localparam logic [2:0]  PROT_VERIFY_LOW  = 3'h2;
  localparam logic [7:0]  PROT_YES         = 8'h01;
  localparam int          POLL_BIT         = 7;
  localparam int          TOGGLE_BIT       = 6;
  localparam int          STEP_MAX         = 6;
  typedef enum logic [2:0] {
    FCST_PROGRAM, FCST_CHIP_ERASE, FCST_BLOCK_ERASE, FCST_SUSPEND,
    FCST_RESUME, FCST_PROT_VERIFY, FCST_READ, FCST_RESET
  } fcst_cmd_t;
endpackage : fcst_pkg

// ---- fcst_bus_if.sv ----
// Interface: one bus cycle request from the sequencer to the bus cycle engine
// Assumes both ends run on the same clock
`timescale 1ns/1ns
interface fcst_bus_if;
  import fcst_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fcst_bus_if

// ---- fcst_cycle.sv ----
// Bus cycle engine: one write or read cycle on the flash pins
// Assumes pin inputs are synchronous to i_clk
`timescale 1ns/1ns
module fcst_cycle
  import fcst_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  fcst_bus_if.eng                bus,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic                   o_ce_n,
  output logic                   o_we_n,
  output logic                   o_oe_n,
  output logic                   o_dq_oe,
  output logic [DATA_W-1:0]      o_dq,
  output logic [ADDR_W-1:0]      o_addr
);
  localparam logic [CNT_W-1:0] HOLD = CNT_W'(CYC_OEHP);
  localparam logic [CNT_W-1:0] GAP  = CNT_W'(CYC_CMD);
  typedef enum {C_IDLE, C_STROBE, C_GAP} fcst_cst_t;
  fcst_cst_t        st_q;
  logic [CNT_W-1:0] cnt_q;
  logic             wr_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q      <= C_IDLE;
      cnt_q     <= '0;
      wr_q      <= 1'b0;
      o_ce_n    <= 1'b1;
      o_we_n    <= 1'b1;
      o_oe_n    <= 1'b1;
      o_dq_oe   <= 1'b0;
      o_dq      <= '0;
      o_addr    <= '0;
      bus.done  <= 1'b0;
      bus.rdata <= '0;
    end else begin
      bus.done <= 1'b0;
      unique case (st_q)
        C_IDLE: begin
          if (bus.req) begin
            st_q    <= C_STROBE;
            cnt_q   <= HOLD;
            wr_q    <= bus.wr;
            o_addr  <= bus.addr;
            o_dq    <= bus.wdata;
            o_dq_oe <= bus.wr;
            o_ce_n  <= 1'b0;
            o_we_n  <= !bus.wr;
            o_oe_n  <= bus.wr;
          end
        end
        C_STROBE: begin
          if (cnt_q == CNT_W'(1)) begin
            st_q   <= C_GAP;
            cnt_q  <= GAP;
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_ce_n <= 1'b1;
            if (!wr_q) begin
              bus.rdata <= i_dq;
            end
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        C_GAP: begin
          o_dq_oe <= 1'b0;
          if (cnt_q == CNT_W'(1)) begin
            st_q     <= C_IDLE;
            bus.done <= 1'b1;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
      endcase
    end
  end

  a_strobe_width: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(o_ce_n) |-> !o_ce_n [*2] ##1 o_ce_n) else $error("strobe length differs from hold time");
endmodule : fcst_cycle

// ---- fcst_host.sv ----
// Host controller: issues program, erase, suspend, resume, reset and protect verify to a NOR flash
// Assumes the flash pins are wired straight to the ports; ready_busy_n is sampled synchronously
`timescale 1ns/1ns
// Behaviour
// - The host holds the hardware reset pin low for at least 500 ns.
// - The host polls at the program address for program, inside the block for block erase, anywhere for chip erase.
// - While erase is suspended the host polls at an address outside the suspended block.
// - A protect verify read uses the block address with bit6, bit1, bit0 set to 0, 1, 0.
module fcst_host
  import fcst_pkg::*;
#(
  parameter int READY_CYC = CYC_READY
)(
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_start,
  input  wire fcst_pkg::fcst_cmd_t i_cmd,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_erase_susp,
  input  wire logic [ADDR_W-1:0] i_outside_addr,
  input  wire logic [DATA_W-1:0] i_dq,
  input  wire logic              i_ready_busy_n,
  output logic                   o_busy,
  output logic                   o_done,
  output logic                   o_fail,
  output logic                   o_protected,
  output logic [DATA_W-1:0]      o_rdata,
  output logic                   o_reset_n,
  output logic                   o_ce_n,
  output logic                   o_we_n,
  output logic                   o_oe_n,
  output logic                   o_dq_oe,
  output logic [DATA_W-1:0]      o_dq,
  output logic [ADDR_W-1:0]      o_addr
);
  import fcst_pkg::*;
  localparam int WT_W = 16;
  typedef enum {H_IDLE, H_SEQ, H_BUSYWAIT, H_POLL, H_WAIT, H_RST_LOW, H_RST_HOLD, H_RST_REC} fcst_hst_t;

  fcst_bus_if bus ();
  fcst_hst_t         st_q;
  fcst_cmd_t         cmd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic [2:0]        step_q;
  logic [WT_W-1:0]   wt_q;
  logic              susp_q;
  logic              tog_q;
  logic              have_tog_q;
  logic              req_q;
  logic              wr_q;
  logic [ADDR_W-1:0] baddr_q;
  logic [DATA_W-1:0] bdata_q;

  assign bus.req   = req_q;
  assign bus.wr    = wr_q;
  assign bus.addr  = baddr_q;
  assign bus.wdata = bdata_q;

  fcst_cycle u_cycle (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .bus      (bus),
    .i_dq     (i_dq),
    .o_ce_n   (o_ce_n),
    .o_we_n   (o_we_n),
    .o_oe_n   (o_oe_n),
    .o_dq_oe  (o_dq_oe),
    .o_dq     (o_dq),
    .o_addr   (o_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequences: number of writes and each address/data pair
  function automatic logic [2:0] seq_len(input fcst_cmd_t c);
    unique case (c)
      FCST_PROGRAM:     seq_len = 3'h4;
      FCST_CHIP_ERASE:  seq_len = 3'h6;
      FCST_BLOCK_ERASE: seq_len = 3'h6;
      default:          seq_len = 3'h1;
    endcase
  endfunction : seq_len

  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input fcst_cmd_t c, input logic [2:0] s,
                                                         input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [ADDR_W-1:0] ua;
    logic [DATA_W-1:0] ud;
    ua = (s == 3'h1 || s == 3'h4) ? ADDR_W'(20'h002AA) : ADDR_W'(20'h00555);
    ud = (s == 3'h1 || s == 3'h4) ? 16'h0055 : 16'h00AA;
    if (s == 3'h2) begin
      ud = (c == FCST_PROGRAM) ? 16'h00A0 : 16'h0080;
    end
    unique case (c)
      FCST_PROGRAM:     if (s == 3'h3) begin ua = a; ud = d; end
      FCST_CHIP_ERASE:  if (s == 3'h5) begin ud = 16'h0010; end
      FCST_BLOCK_ERASE: if (s == 3'h5) begin ua = a; ud = 16'h0030; end
      FCST_SUSPEND:     begin ua = a; ud = 16'h00B0; end
      FCST_RESUME:      begin ua = a; ud = 16'h0030; end
      default:          begin ua = a; ud = d; end
    endcase
    seq_word = {ua, ud};
  endfunction : seq_word

  // Address at which status is polled
  function automatic logic [ADDR_W-1:0] poll_address(input fcst_cmd_t c, input logic s,
                                                      input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    if (s) begin
      poll_address = o;
    end else if (c == FCST_CHIP_ERASE) begin
      poll_address = '0;
    end else begin
      poll_address = a;
    end
  endfunction : poll_address

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q        <= H_IDLE;
      cmd_q       <= FCST_READ;
      addr_q      <= '0;
      data_q      <= '0;
      step_q      <= '0;
      wt_q        <= '0;
      susp_q      <= 1'b0;
      tog_q       <= 1'b0;
      have_tog_q  <= 1'b0;
      req_q       <= 1'b0;
      wr_q        <= 1'b0;
      baddr_q     <= '0;
      bdata_q     <= '0;
      o_busy      <= 1'b0;
      o_done      <= 1'b0;
      o_fail      <= 1'b0;
      o_protected <= 1'b0;
      o_rdata     <= '0;
      o_reset_n   <= 1'b1;
    end else begin
      o_done <= 1'b0;
      req_q  <= 1'b0;
      unique case (st_q)
        H_IDLE: begin
          if (i_start) begin
            cmd_q  <= i_cmd;
            addr_q <= (i_cmd == FCST_PROT_VERIFY) ? {i_addr[ADDR_W-1:7], 1'b0, i_addr[5:2], PROT_VERIFY_LOW[1:0]}
                                                  : i_addr;
            data_q <= i_data;
            susp_q <= i_erase_susp;
            step_q <= '0;
            o_busy <= 1'b1;
            o_fail <= 1'b0;
            if (i_cmd == FCST_RESET) begin
              st_q      <= H_RST_LOW;
              o_reset_n <= 1'b0;
              wt_q      <= WT_W'(CYC_RP);
            end else begin
              st_q <= H_SEQ;
            end
          end
        end
        H_SEQ: begin
          if (!req_q && !bus.done && step_q < seq_len(cmd_q)) begin
            req_q   <= 1'b1;
            wr_q    <= !(cmd_q == FCST_READ || cmd_q == FCST_PROT_VERIFY);
            {baddr_q, bdata_q} <= seq_word(cmd_q, step_q, addr_q, data_q);
          end
          if (bus.done) begin
            step_q <= step_q + 3'h1;
            if (step_q + 3'h1 == seq_len(cmd_q)) begin
              unique case (cmd_q)
                FCST_READ, FCST_PROT_VERIFY: begin
                  st_q        <= H_IDLE;
                  o_busy      <= 1'b0;
                  o_done      <= 1'b1;
                  o_rdata     <= bus.rdata;
                  o_protected <= bus.rdata[7:0] == PROT_YES;
                end
                FCST_SUSPEND: begin
                  st_q <= H_WAIT;
                  wt_q <= WT_W'(susp_q ? CYC_SUSP_ERASE : CYC_SUSP_PROG);
                end
                FCST_RESUME: begin
                  st_q <= H_WAIT;
                  wt_q <= WT_W'(CYC_RESUME);
                end
                default: begin
                  st_q <= H_BUSYWAIT;
                  wt_q <= WT_W'(susp_q ? CYC_BUSY_SUSP : CYC_BUSY);
                end
              endcase
            end
          end
        end
        H_BUSYWAIT: begin
          if (wt_q == WT_W'(1)) begin
            st_q       <= H_POLL;
            have_tog_q <= 1'b0;
          end else begin
            wt_q <= wt_q - WT_W'(1);
          end
        end
        H_POLL: begin
          if (!req_q && !bus.done) begin
            req_q   <= 1'b1;
            wr_q    <= 1'b0;
            baddr_q <= poll_address(cmd_q, susp_q, addr_q, i_outside_addr);
          end
          if (bus.done) begin
            tog_q      <= bus.rdata[TOGGLE_BIT];
            have_tog_q <= 1'b1;
            // Ready and toggle stopped means the flash is back in read mode
            if (i_ready_busy_n && have_tog_q && tog_q == bus.rdata[TOGGLE_BIT]) begin
              st_q    <= H_IDLE;
              o_busy  <= 1'b0;
              o_done  <= 1'b1;
              o_rdata <= bus.rdata;
              o_fail  <= cmd_q == FCST_PROGRAM && bus.rdata[POLL_BIT] != data_q[POLL_BIT];
            end
          end
        end
        H_WAIT: begin
          if (wt_q == WT_W'(1)) begin
            st_q   <= H_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end else begin
            wt_q <= wt_q - WT_W'(1);
          end
        end
        H_RST_LOW: begin
          if (wt_q == WT_W'(1)) begin
            st_q      <= H_RST_HOLD;
            o_reset_n <= 1'b1;
            wt_q      <= WT_W'(READY_CYC - CYC_RP);
          end else begin
            wt_q <= wt_q - WT_W'(1);
          end
        end
        H_RST_HOLD: begin
          if (wt_q <= WT_W'(1)) begin
            st_q <= H_RST_REC;
            wt_q <= WT_W'(CYC_RH);
          end else begin
            wt_q <= wt_q - WT_W'(1);
          end
        end
        H_RST_REC: begin
          if (wt_q == WT_W'(1)) begin
            st_q   <= H_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end else begin
            wt_q <= wt_q - WT_W'(1);
          end
        end
      endcase
    end
  end

  a_reset_width: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(o_reset_n) |-> !o_reset_n [*8]) else $error("reset pulse too short");
  a_reset_recover: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(o_reset_n) |-> o_ce_n [*2]) else $error("bus cycle too soon after reset");
  a_verify_addr: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == H_SEQ && cmd_q == FCST_PROT_VERIFY && !o_ce_n) |->
    (o_addr[6] == 1'b0 && o_addr[1:0] == 2'h2)) else $error("protect verify address wrong");
  a_suspend_addr: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == H_POLL && susp_q && !o_ce_n) |-> o_addr == i_outside_addr) else $error("poll inside suspended block");
  a_prot_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == H_SEQ && cmd_q == FCST_PROT_VERIFY && bus.done) |=> o_protected == (o_rdata[7:0] == 8'h01))
    else $error("protect flag wrong");
  a_busy_wait: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == H_SEQ && bus.done && cmd_q == FCST_PROGRAM && step_q == 3'h3) |=> st_q == H_BUSYWAIT)
    else $error("program did not wait for busy");
  a_done_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_done |-> !o_busy && st_q == H_IDLE) else $error("done while still busy");
  a_poll_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q == H_POLL && !o_ce_n) |-> !o_dq_oe) else $error("poll cycle drives data");
endmodule : fcst_host

// ---- fcst_flash_model.sv ----
// Flash partner: command decoder, busy timer, status flags, protect verify read
// Assumes host pins are sampled on i_clk; a released data bus shows the inverse of the last value
`timescale 1ns/1ns
module fcst_flash_model
  import fcst_pkg::*;
#(
  parameter int         BUSY_CYC = 8,
  parameter logic [7:0] PROT_BLK = 8'h3C
)(
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_ce_n,
  input  wire logic              i_we_n,
  input  wire logic              i_oe_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0]      o_dq,
  output logic                   o_ready_busy_n
);
  int                wcnt;
  int                bcnt;
  logic              susp, tog, erase, we_q, oe_q;
  logic [7:0]        mode;
  logic [ADDR_W-1:0] pa;
  logic [DATA_W-1:0] pd, rd, last;
  ////////////////////////////////////////////////////////////
  always_comb begin
    if (bcnt > 0) rd = {8'h00, ~erase & ~pd[7], tog, 6'h00};
    else if (!i_addr[6] && i_addr[1:0] == 2'h2) rd = {15'h0, i_addr[19:12] == PROT_BLK};
    else if (i_addr == pa) rd = pd;
    else rd = i_addr[15:0] ^ 16'h5A5A;
  end
  assign o_dq           = (!i_ce_n && !i_oe_n) ? rd : ~last;
  assign o_ready_busy_n = (bcnt == 0);
  ////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wcnt <= 0;
      bcnt <= 0;
      susp <= 1'b0;
      tog  <= 1'b0;
      we_q <= 1'b1;
      oe_q <= 1'b1;
      last <= '0;
    end else begin
      we_q <= i_we_n;
      oe_q <= i_oe_n;
      if (!i_oe_n) last <= rd;
      if (oe_q && !i_oe_n && bcnt > 0) tog <= ~tog;
      if (bcnt > 0) bcnt <= bcnt - 1;
      if (we_q && !i_we_n) begin
        wcnt <= wcnt + 1;
        if (wcnt == 0 && i_dq[7:0] == 8'hB0) begin
          susp <= 1'b1;
          wcnt <= 0;
        end else if (wcnt == 0 && i_dq[7:0] == 8'h30) begin
          susp <= 1'b0;
          wcnt <= 0;
        end else if (wcnt == 2) mode <= i_dq[7:0];
        else if (wcnt == 3 && mode == 8'hA0) begin
          bcnt  <= BUSY_CYC;
          erase <= 1'b0;
          pa    <= i_addr;
          pd    <= i_dq;
          wcnt  <= 0;
        end else if (wcnt == 5) begin
          bcnt  <= BUSY_CYC;
          erase <= 1'b1;
          wcnt  <= 0;
        end
      end
    end
  end
endmodule : fcst_flash_model

// ---- fcst_host_tb.sv ----
// Testbench: host controller against the flash partner, pin traffic and results compared
// Assumes the package constants and a 20 MHz clock
`timescale 1ns/1ns
module fcst_host_tb;
  import fcst_pkg::*;
  localparam int         RDY = 20;
  localparam logic [7:0] PB  = 8'h3C;
  logic              i_clk, i_arst_n, i_start, i_erase_susp, rbn;
  fcst_cmd_t         i_cmd;
  logic [ADDR_W-1:0] i_addr, i_outside_addr, o_addr, pa, ba, oa, a;
  logic [DATA_W-1:0] i_data, i_dq, o_dq, o_rdata, pd;
  logic              o_busy, o_done, o_fail, o_protected, o_reset_n;
  logic              o_ce_n, o_we_n, o_oe_n, o_dq_oe, first;
  logic              pw = 1'b1, po = 1'b1, pr = 1'b1;
  int                n_errors, tests_run, cyc, tw, tw0, td, gap, rlow, trf, trr;
  logic [35:0]       wq[$];
  logic [ADDR_W-1:0] rq[$];
  fcst_host #(.READY_CYC(RDY)) fcst_host_inst (
    .i_clk, .i_arst_n, .i_start, .i_cmd, .i_addr, .i_data, .i_erase_susp, .i_outside_addr,
    .i_dq, .i_ready_busy_n(rbn), .o_busy, .o_done, .o_fail, .o_protected, .o_rdata,
    .o_reset_n, .o_ce_n, .o_we_n, .o_oe_n, .o_dq_oe, .o_dq, .o_addr);
  fcst_flash_model #(.BUSY_CYC(8), .PROT_BLK(PB)) fcst_flash_model_inst (
    .i_clk, .i_reset_n(o_reset_n), .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
    .i_addr(o_addr), .i_dq(o_dq_oe ? o_dq : i_dq), .o_dq(i_dq), .o_ready_busy_n(rbn));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    pw  <= o_we_n;
    po  <= o_oe_n;
    pr  <= o_reset_n;
    if (i_start) gap <= -1;
    if (pw && !o_we_n) begin
      if (wq.size() == 0) tw0 <= cyc;
      wq.push_back({o_addr, o_dq});
      tw    <= cyc;
      first <= 1'b1;
    end
    if (po && !o_oe_n) begin
      rq.push_back(o_addr);
      first <= 1'b0;
      if (first) gap <= cyc - tw;
    end
    if (!o_reset_n) rlow <= rlow + 1;
    if (pr && !o_reset_n) trf <= cyc;
    if (!pr && o_reset_n) trr <= cyc;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic cmd(input fcst_cmd_t c, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d, input logic es);
    int k;
    wq.delete();
    rq.delete();
    @(posedge i_clk);
    i_cmd          <= c;
    i_addr         <= ad;
    i_data         <= d;
    i_erase_susp   <= es;
    i_outside_addr <= oa;
    i_start        <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    @(negedge i_clk);
    chk("busy", o_busy, 1);
    k = 0;
    while (o_done !== 1'b1 && k < 20000) begin
      @(negedge i_clk);
      k++;
    end
    td = cyc;
    if (k >= 20000) begin
      n_errors++;
      end_of_test();
    end
    chk("idle", o_busy, 0);
  endtask : cmd
  task automatic ew(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    chk("write", wq.size() ? wq.pop_front() : '1, {ad, d});
  endtask : ew
  task automatic unlock(input logic [DATA_W-1:0] d);
    ew(20'h00555, 16'h00AA);
    ew(20'h002AA, 16'h0055);
    ew(20'h00555, d);
  endtask : unlock
  task automatic pchk(input logic [ADDR_W-1:0] e, input logic [ADDR_W-1:0] m);
    chk("polls", rq.size() > 0, 1);
    foreach (rq[i]) chk("poll_addr", rq[i] & m, e & m);
  endtask : pchk
  ////////////////////////////////////////////////////////////
  initial begin
    i_arst_n       = 1'b0;
    i_start        = 1'b0;
    i_cmd          = FCST_READ;
    i_addr         = '0;
    i_data         = '0;
    i_erase_susp   = 1'b0;
    i_outside_addr = '0;
    oa             = '0;
    void'($urandom(32'hB7FB0C86));
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    cmd(FCST_RESET, '0, '0, 1'b0);
    chk("reset_low", rlow >= CYC_RP, 1);
    chk("reset_wait", td - trf >= RDY, 1);
    repeat (3) begin
      pa = 20'($urandom) | 20'h00001;
      pd = 16'($urandom);
      cmd(FCST_PROGRAM, pa, pd, 1'b0);
      chk("recovery", tw0 - trr >= CYC_RH, 1);
      unlock(16'h00A0);
      ew(pa, pd);
      pchk(pa, '1);
      chk("busy_wait", gap >= CYC_BUSY + 2, 1);
      chk("fail", o_fail, 0);
      chk("ready", rbn, 1);
      cmd(FCST_READ, pa, '0, 1'b0);
      chk("rdata", o_rdata, pd);
    end
    ba = 20'($urandom) & 20'hFF000;
    oa = ba ^ 20'h80000;
    cmd(FCST_CHIP_ERASE, ba, '0, 1'b0);
    unlock(16'h0080);
    unlock(16'h0010);
    pchk('0, '1);
    cmd(FCST_BLOCK_ERASE, ba, '0, 1'b0);
    unlock(16'h0080);
    ew(20'h00555, 16'h00AA);
    ew(20'h002AA, 16'h0055);
    ew(ba, 16'h0030);
    pchk(ba, 20'hFF000);
    for (int es = 0; es < 2; es++) begin
      cmd(FCST_SUSPEND, ba, '0, es[0]);
      ew(ba, 16'h00B0);
      chk("susp_wait", td - tw >= (es ? CYC_SUSP_ERASE : CYC_SUSP_PROG) + 2, 1);
      if (es) begin
        cmd(FCST_PROGRAM, pa, pd, 1'b1);
        pchk(oa, '1);
        chk("susp_busy", gap >= CYC_BUSY_SUSP + 2, 1);
      end
      cmd(FCST_RESUME, ba, '0, es[0]);
      ew(ba, 16'h0030);
      chk("resume_wait", td - tw >= CYC_RESUME + 2, 1);
    end
    for (int i = 0; i < 2; i++) begin
      a = {i ? PB : ~PB, 12'($urandom)};
      cmd(FCST_PROT_VERIFY, a, '0, 1'b0);
      chk("pv_addr", {rq[0][19:12], rq[0][6], rq[0][1:0]}, {a[19:12], 3'h2});
      chk("protected", o_protected, i);
      chk("pv_data", o_rdata, i);
    end
    end_of_test();
  end
endmodule : fcst_host_tb
